// >>> core/sdr_pkg.sv
// Constants and types of the monitoring data and status responder
package sdr_pkg;
    // Command and subcommand codes
    localparam logic [7:0] SDR_CMD_MON = 8'hb0;
    localparam logic [7:0] SDR_SUB_READ_DATA = 8'hd0;
    localparam logic [7:0] SDR_SUB_SAVE_ATTR = 8'hd3;
    localparam logic [7:0] SDR_SUB_RUN_OFFLINE = 8'hd4;
    localparam logic [7:0] SDR_SUB_READ_LOG = 8'hd5;
    localparam logic [7:0] SDR_SUB_WRITE_LOG = 8'hd6;
    localparam logic [7:0] SDR_SUB_ENABLE = 8'hd8;
    localparam logic [7:0] SDR_SUB_DISABLE = 8'hd9;
    localparam logic [7:0] SDR_SUB_STATUS = 8'hda;
    // Signatures for the reliability query
    localparam logic [7:0] SDR_SIG_OK_LO = 8'h4f;
    localparam logic [7:0] SDR_SIG_OK_HI = 8'hc2;
    localparam logic [7:0] SDR_SIG_BAD_LO = 8'hf4;
    localparam logic [7:0] SDR_SIG_BAD_HI = 8'h2c;
    // Sector geometry and byte positions
    localparam logic [8:0] SDR_LAST_BYTE = 9'h1ff;
    localparam logic [8:0] SDR_POS_STATUS = 9'h16a;
    localparam logic [8:0] SDR_POS_TIME_LO = 9'h16c;
    localparam logic [8:0] SDR_POS_TIME_HI = 9'h16d;
    localparam logic [8:0] SDR_POS_OFF_CAP = 9'h16f;
    localparam logic [8:0] SDR_POS_CAP_LO = 9'h170;
    localparam logic [8:0] SDR_POS_CAP_HI = 9'h171;
    localparam logic [8:0] SDR_POS_RSV_FIRST = 9'h172;
    localparam logic [8:0] SDR_POS_RSV_LAST = 9'h181;
    // Collection status codes, low seven bits
    localparam logic [6:0] SDR_ST_NEVER = 7'h00;
    localparam logic [6:0] SDR_ST_DONE = 7'h02;
    localparam logic [6:0] SDR_ST_SUSP = 7'h04;
    localparam logic [6:0] SDR_ST_ABORT_HOST = 7'h05;
    localparam logic [6:0] SDR_ST_FATAL = 7'h06;
    // Fixed capability values
    localparam logic [7:0] SDR_OFF_CAP = 8'h05;
    localparam logic [15:0] SDR_CAP_WORD = 16'h0003;
    localparam int SDR_OFF_CAP_ABORT_BIT = 2;
    localparam int SDR_CAP_POWER_SAVE_BIT = 0;
    // Log sector count
    localparam int SDR_LOG_SECTORS = 4;
    // Responder states
    typedef enum logic [2:0] {
        SDR_IDLE, SDR_SUM, SDR_SEND, SDR_RECV, SDR_DONE
    } sdr_state_t;
endpackage

// >>> core/sdr_responder.sv
// Monitoring data, log and reliability status responder
`timescale 1ns/1ps
`default_nettype none
module sdr_responder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,          // One-cycle pulse: command register written
    input wire logic [7:0] cmd_code,     // Command opcode
    input wire logic [7:0] feature,      // Feature register value
    input wire logic [7:0] log_addr,     // Log sector select
    input wire logic mon_enabled,        // Monitoring enabled level
    input wire logic thresh_exceeded,    // Threshold exceeded level
    input wire logic [15:0] offline_secs,// Seconds to finish collection
    input wire logic offline_run,        // Pulse: collection started
    input wire logic offline_done,       // Pulse: collection finished
    input wire logic offline_fatal,      // Pulse: collection failed
    input wire logic resume_event,       // Pulse: vendor event to resume
    input wire logic auto_flag,          // Level: automatic collection on
    input wire logic power_save_req,     // Pulse: power mode change pending
    input wire logic [7:0] vendor_byte,  // Vendor byte for current index
    input wire logic rd_ack,             // Host took rd_data this cycle
    input wire logic wr_valid,           // Host write byte valid
    input wire logic [7:0] wr_data,      // Host write byte
    output logic [8:0] byte_idx,         // Byte index being handled
    output logic [7:0] rd_data,          // Data-in byte
    output logic rd_valid,               // Data-in byte valid
    output logic busy,                   // Command in progress
    output logic done,                   // One-cycle completion pulse
    output logic aborted,                // Completion with aborted error
    output logic cyl_lo_we,              // Pulse: load cylinder low
    output logic [7:0] cyl_lo,           // Cylinder low value
    output logic [7:0] cyl_hi,           // Cylinder high value
    output logic save_pulse,             // Pulse: commit attributes
    output logic offline_active          // Collection in progress
);
    // Module state apart from the log memory and its registered read byte
    typedef struct packed {
        sdr_pkg::sdr_state_t st;
        logic [8:0] idx;
        logic [7:0] sum;
        logic [7:0] rd_data;
        logic rd_valid;
        logic is_log;
        logic [1:0] log_sel;
        logic busy;
        logic done;
        logic aborted;
        logic cyl_we;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic save;
        logic active;
        logic [6:0] ostat;
    } sdr_regs_t;

    sdr_regs_t q, d;
    logic [7:0] log_mem [0:sdr_pkg::SDR_LOG_SECTORS*512-1]; // Log storage
    logic [7:0] log_rd_q;  // Registered log byte
    logic [7:0] struct_byte; // Structure byte at idx, checksum excluded
    logic [7:0] out_byte;    // Byte as transferred
    logic [10:0] mem_addr;   // Sector select over byte index
    logic is_mon;            // Monitoring command strobe this cycle

    // Log memory address from selected sector and byte index
    assign mem_addr = {q.log_sel, q.idx};

    // Byte values of the data structure at the current index
    // Vendor bytes pass through unless a fixed or variable field overrides them
    always_comb begin
        struct_byte = vendor_byte;
        if (q.idx == sdr_pkg::SDR_POS_STATUS) begin
            struct_byte = {auto_flag, q.ostat};
        end else if (q.idx == sdr_pkg::SDR_POS_TIME_LO) begin
            // Low byte first; zero clamped to one keeps the field legal
            struct_byte = (offline_secs == 16'h0000) ? 8'h01 : offline_secs[7:0];
        end else if (q.idx == sdr_pkg::SDR_POS_TIME_HI) begin
            struct_byte = offline_secs[15:8];
        end else if (q.idx == sdr_pkg::SDR_POS_OFF_CAP) begin
            struct_byte = sdr_pkg::SDR_OFF_CAP;
        end else if (q.idx == sdr_pkg::SDR_POS_CAP_LO) begin
            struct_byte = sdr_pkg::SDR_CAP_WORD[7:0];
        end else if (q.idx == sdr_pkg::SDR_POS_CAP_HI) begin
            struct_byte = sdr_pkg::SDR_CAP_WORD[15:8];
        end else if (q.idx >= sdr_pkg::SDR_POS_RSV_FIRST &&
                     q.idx <= sdr_pkg::SDR_POS_RSV_LAST) begin
            struct_byte = 8'h00;
        end
        // Checksum byte closes the sector
        if (q.idx == sdr_pkg::SDR_LAST_BYTE) begin
            out_byte = 8'h00 - q.sum;
        end else begin
            out_byte = struct_byte;
        end
        is_mon = cmd_valid && cmd_code == sdr_pkg::SDR_CMD_MON;
    end

    // Log memory: written during receive, read ahead during send
    always_ff @(posedge clk) begin
        if (q.st == sdr_pkg::SDR_RECV && wr_valid) begin
            log_mem[mem_addr] <= wr_data;
        end
        log_rd_q <= log_mem[mem_addr];
    end

    // Next-state logic of the responder
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.aborted = 1'b0;
        d.cyl_we = 1'b0;
        d.save = 1'b0;
        // Collection status tracking
        if (offline_run) begin
            d.active = 1'b1;
        end else if (offline_done && q.active) begin
            d.active = 1'b0;
            d.ostat = sdr_pkg::SDR_ST_DONE;
        end else if (offline_fatal && q.active) begin
            d.active = 1'b0;
            d.ostat = sdr_pkg::SDR_ST_FATAL;
        end else if (resume_event && q.ostat == sdr_pkg::SDR_ST_SUSP) begin
            d.active = 1'b1;
        end
        // Any other new command interrupts running collection
        if (cmd_valid && q.active && !offline_run &&
            !(is_mon && (feature == sdr_pkg::SDR_SUB_RUN_OFFLINE ||
                         feature == sdr_pkg::SDR_SUB_DISABLE))) begin
            d.active = 1'b0;
            if (sdr_pkg::SDR_OFF_CAP[sdr_pkg::SDR_OFF_CAP_ABORT_BIT]) begin
                d.ostat = sdr_pkg::SDR_ST_ABORT_HOST;
            end else begin
                d.ostat = sdr_pkg::SDR_ST_SUSP;
            end
        end
        // Power mode save when capability word allows it
        if (power_save_req && sdr_pkg::SDR_CAP_WORD[sdr_pkg::SDR_CAP_POWER_SAVE_BIT]) begin
            d.save = 1'b1;
        end
        case (q.st)
            sdr_pkg::SDR_IDLE: begin
                if (is_mon) begin
                    d.idx = 9'h000;
                    d.sum = 8'h00;
                    if (!mon_enabled && feature != sdr_pkg::SDR_SUB_ENABLE) begin
                        d.busy = 1'b1;
                        d.aborted = 1'b1;
                        d.st = sdr_pkg::SDR_DONE;
                    end else begin
                        d.busy = 1'b1;
                        d.st = sdr_pkg::SDR_DONE;
                        case (feature)
                            sdr_pkg::SDR_SUB_READ_DATA: begin
                                d.is_log = 1'b0;
                                d.st = sdr_pkg::SDR_SEND;
                            end
                            sdr_pkg::SDR_SUB_READ_LOG: begin
                                d.is_log = 1'b1;
                                d.log_sel = log_addr[1:0];
                                d.st = sdr_pkg::SDR_SUM;
                            end
                            sdr_pkg::SDR_SUB_WRITE_LOG: begin
                                d.log_sel = log_addr[1:0];
                                d.st = sdr_pkg::SDR_RECV;
                            end
                            sdr_pkg::SDR_SUB_SAVE_ATTR: begin
                                d.save = 1'b1;
                            end
                            sdr_pkg::SDR_SUB_STATUS: begin
                                d.cyl_we = 1'b1;
                                d.cyl_lo = thresh_exceeded ? sdr_pkg::SDR_SIG_BAD_LO
                                                           : sdr_pkg::SDR_SIG_OK_LO;
                                d.cyl_hi = thresh_exceeded ? sdr_pkg::SDR_SIG_BAD_HI
                                                           : sdr_pkg::SDR_SIG_OK_HI;
                            end
                            sdr_pkg::SDR_SUB_ENABLE, sdr_pkg::SDR_SUB_DISABLE,
                            sdr_pkg::SDR_SUB_RUN_OFFLINE: begin
                                d.st = sdr_pkg::SDR_DONE;
                            end
                            default: begin
                                d.aborted = 1'b1;
                            end
                        endcase
                    end
                end
            end
            sdr_pkg::SDR_SUM: begin
                // One cycle of read latency before the log byte is usable
                d.st = sdr_pkg::SDR_SEND;
            end
            sdr_pkg::SDR_SEND: begin
                d.rd_valid = 1'b1;
                d.rd_data = q.is_log ? log_rd_q : out_byte;
                if (q.rd_valid && rd_ack) begin
                    d.sum = q.sum + q.rd_data;
                    if (q.idx == sdr_pkg::SDR_LAST_BYTE) begin
                        d.rd_valid = 1'b0;
                        d.st = sdr_pkg::SDR_DONE;
                    end else begin
                        d.idx = q.idx + 9'h001;
                        d.rd_valid = 1'b0;
                        d.st = q.is_log ? sdr_pkg::SDR_SUM : sdr_pkg::SDR_SEND;
                    end
                end
            end
            sdr_pkg::SDR_RECV: begin
                if (wr_valid) begin
                    if (q.idx == sdr_pkg::SDR_LAST_BYTE) begin
                        d.st = sdr_pkg::SDR_DONE;
                    end else begin
                        d.idx = q.idx + 9'h001;
                    end
                end
            end
            sdr_pkg::SDR_DONE: begin
                d.busy = 1'b0;
                d.done = 1'b1;
                d.aborted = q.aborted;
                d.st = sdr_pkg::SDR_IDLE;
            end
            default: begin
                d.st = sdr_pkg::SDR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign byte_idx = q.idx;
    assign rd_data = q.rd_data;
    assign rd_valid = q.rd_valid;
    assign busy = q.busy;
    assign done = q.done;
    assign aborted = q.aborted;
    assign cyl_lo_we = q.cyl_we;
    assign cyl_lo = q.cyl_lo;
    assign cyl_hi = q.cyl_hi;
    assign save_pulse = q.save;
    assign offline_active = q.active;

    // Checks, kept beside the state they watch

    // Refused request: monitoring disabled and not the enable code
    sequence s_refused_req;
        q.st == sdr_pkg::SDR_IDLE && is_mon && !mon_enabled &&
        feature != sdr_pkg::SDR_SUB_ENABLE;
    endsequence

    // The refusal closes one cycle after the done state is entered
    sequence s_abort_done;
        ##1 (done && aborted);
    endsequence

    // Good signature loads both cylinder bytes beside the write pulse
    a_status_good: assert property (@(posedge clk) disable iff (!rst_n)
        (q.st == sdr_pkg::SDR_IDLE && is_mon && mon_enabled && !thresh_exceeded &&
         feature == sdr_pkg::SDR_SUB_STATUS) |=>
        (cyl_lo_we && cyl_lo == sdr_pkg::SDR_SIG_OK_LO && cyl_hi == sdr_pkg::SDR_SIG_OK_HI))
        else $error("bad good signature");

    // Threshold signature replaces the good one when the level is high
    a_status_bad: assert property (@(posedge clk) disable iff (!rst_n)
        (q.st == sdr_pkg::SDR_IDLE && is_mon && mon_enabled && thresh_exceeded &&
         feature == sdr_pkg::SDR_SUB_STATUS) |=>
        (cyl_lo == sdr_pkg::SDR_SIG_BAD_LO && cyl_hi == sdr_pkg::SDR_SIG_BAD_HI))
        else $error("bad threshold signature");

    // Disabled monitoring refuses everything but the enable code
    a_disabled_abort: assert property (@(posedge clk) disable iff (!rst_n)
        s_refused_req |=> s_abort_done)
        else $error("disabled command not aborted");

    // Whole sector sums to zero once the checksum byte is shown
    a_checksum_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (q.st == sdr_pkg::SDR_SEND && !q.is_log && q.idx == sdr_pkg::SDR_LAST_BYTE && rd_valid)
        |-> (8'(q.sum + rd_data) == 8'h00))
        else $error("checksum wrong");

    // Reserved span never carries vendor data
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_valid && !q.is_log && q.idx >= sdr_pkg::SDR_POS_RSV_FIRST &&
         q.idx <= sdr_pkg::SDR_POS_RSV_LAST) |-> rd_data == 8'h00)
        else $error("reserved nonzero");

    // Autosave-after-event bit is set in the low capability byte
    a_cap_bytes: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_valid && !q.is_log && q.idx == sdr_pkg::SDR_POS_CAP_LO) |-> rd_data[1])
        else $error("autosave bit clear");

    // Commit pulse follows the save request at once
    a_save_now: assert property (@(posedge clk) disable iff (!rst_n)
        (q.st == sdr_pkg::SDR_IDLE && is_mon && mon_enabled &&
         feature == sdr_pkg::SDR_SUB_SAVE_ATTR) |=> save_pulse)
        else $error("save not issued");

    // Any interrupting command, monitoring ones included, ends collection;
    // only the collection start and disable codes are let through
    a_abort_on_cmd: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && offline_active && !offline_run &&
         !(is_mon && (feature == sdr_pkg::SDR_SUB_RUN_OFFLINE ||
                      feature == sdr_pkg::SDR_SUB_DISABLE)))
        |=> (!offline_active && q.ostat == sdr_pkg::SDR_ST_ABORT_HOST))
        else $error("collection not aborted");
endmodule
`default_nettype wire

// >>> testbench/sdr_host_model.sv
// Host controller model: issues monitoring commands and moves sector bytes
`timescale 1ns/1ps
`default_nettype none
module sdr_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] feature,
    output logic [7:0] log_addr,
    output logic rd_ack,
    output logic wr_valid,
    output logic [7:0] wr_data,
    output logic [7:0] vendor_byte,
    input wire logic [8:0] byte_idx,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic done,
    input wire logic aborted,
    input wire logic cyl_lo_we,
    input wire logic save_pulse
);
    logic [7:0] rx [512];     // Bytes received, in arrival order
    logic [8:0] rx_idx [512]; // Index shown beside each byte
    logic got_abort;          // Last completion carried an abort
    logic got_we;             // Cylinder load seen during last command
    logic got_save;           // Commit pulse seen during last command
    int timeouts = 0;         // Waits that ran out
    int gap = 0;              // Extra cycles held before each acknowledge

    // Vendor bytes follow the index, so the bench can predict the whole sector
    assign vendor_byte = byte_idx[7:0] ^ 8'h5a;

    // Idle levels at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        feature = 8'h00;
        log_addr = 8'h00;
        rd_ack = 1'b0;
        wr_valid = 1'b0;
        wr_data = 8'h00;
    end

    // Fill pattern for log sectors
    function automatic logic [7:0] pat(input logic [7:0] seed, input int i);
        return 8'(i * 3) + seed + 8'(i >> 8);
    endfunction

    // Subcommand code rides in the feature value of the same request
    task automatic send(input logic [7:0] sub, input logic [7:0] sector);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= sdr_pkg::SDR_CMD_MON;
        feature <= sub;
        log_addr <= sector;
        got_we = 1'b0;
        got_save = 1'b0;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask

    // Waits for the completion pulse, noting side pulses on the way
    task automatic wait_done();
        for (int n = 0; n < 2000; n++) begin
            @(posedge clk);
            if (cyl_lo_we === 1'b1) got_we = 1'b1;
            if (save_pulse === 1'b1) got_save = 1'b1;
            if (done === 1'b1) begin
                got_abort = aborted;
                return;
            end
        end
        timeouts++;
    endtask

    // Takes 512 bytes; ack is held one cycle, after an optional stall
    task automatic read_sector();
        int n;
        for (int i = 0; i < 512; i++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (rd_valid !== 1'b1 && n < 100);
            if (rd_valid !== 1'b1) begin
                timeouts++;
                return;
            end
            rx[i] = rd_data;
            rx_idx[i] = byte_idx;
            repeat (gap) @(posedge clk);
            rd_ack <= 1'b1;
            @(posedge clk);
            rd_ack <= 1'b0;
        end
    endtask

    // Sends one whole sector, with a stall every 64 bytes
    task automatic write_sector(input logic [7:0] seed);
        for (int i = 0; i < 512; i++) begin
            if (i % 64 == 63) begin
                wr_valid <= 1'b0;
                wr_data <= ~wr_data; // Released data is not left looking valid
                @(posedge clk);
            end
            wr_valid <= 1'b1;
            wr_data <= pat(seed, i);
            @(posedge clk);
        end
        wr_valid <= 1'b0;
        wr_data <= ~wr_data;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the monitoring data and status responder
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, mon_enabled, thresh_exceeded, auto_flag;
    logic offline_run, offline_done, offline_fatal, power_save_req;
    logic [15:0] offline_secs;
    logic cmd_valid, rd_ack, wr_valid, rd_valid, busy, done, aborted;
    logic cyl_lo_we, save_pulse, offline_active;
    logic [7:0] cmd_code, feature, log_addr, wr_data, vendor_byte, rd_data, cyl_lo, cyl_hi;
    logic [8:0] byte_idx;
    int num_errors = 0;
    int check_count = 0;

    sdr_responder uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .feature(feature), .log_addr(log_addr), .mon_enabled(mon_enabled),
        .thresh_exceeded(thresh_exceeded), .offline_secs(offline_secs),
        .offline_run(offline_run), .offline_done(offline_done), .offline_fatal(offline_fatal),
        .resume_event(1'b0), .auto_flag(auto_flag), .power_save_req(power_save_req),
        .vendor_byte(vendor_byte), .rd_ack(rd_ack), .wr_valid(wr_valid), .wr_data(wr_data),
        .byte_idx(byte_idx), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .done(done),
        .aborted(aborted), .cyl_lo_we(cyl_lo_we), .cyl_lo(cyl_lo), .cyl_hi(cyl_hi),
        .save_pulse(save_pulse), .offline_active(offline_active));

    sdr_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .feature(feature), .log_addr(log_addr), .rd_ack(rd_ack), .wr_valid(wr_valid),
        .wr_data(wr_data), .vendor_byte(vendor_byte), .byte_idx(byte_idx), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .aborted(aborted), .cyl_lo_we(cyl_lo_we),
        .save_pulse(save_pulse));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Compares one value, counting every call
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle pulse on {power_save_req, offline_fatal, offline_done, offline_run}
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        {power_save_req, offline_fatal, offline_done, offline_run} <= m;
        @(posedge clk);
        {power_save_req, offline_fatal, offline_done, offline_run} <= 4'h0;
    endtask

    // Reads the data structure and checks its fixed and variable fields
    task automatic read_data(input logic [7:0] st, input logic [15:0] secs);
        logic [7:0] sum;
        host.send(sdr_pkg::SDR_SUB_READ_DATA, 8'h00);
        host.read_sector();
        host.wait_done();
        check(16'(host.got_abort), 16'h0000);
        sum = 8'h00;
        for (int i = 0; i < 512; i++) begin
            sum = sum + host.rx[i];
            check(16'(host.rx_idx[i]), 16'(i));
            if (i >= 370 && i <= 385) check(16'(host.rx[i]), 16'h0000);
        end
        check(16'(host.rx[362]), 16'(st));
        check({host.rx[365], host.rx[364]}, secs);
        check(16'(host.rx[367]), 16'h0005);
        check(16'(host.rx[367][0]), 16'h0001);
        check({host.rx[369], host.rx[368]}, 16'h0003);
        check(16'(host.rx[368][1]), 16'h0001);
        check(16'(sum), 16'h0000);
        check(16'(host.rx[100]), 16'h003e);
    endtask

    // Starts collection: the command, then the firmware's start pulse
    task automatic start_run();
        host.send(sdr_pkg::SDR_SUB_RUN_OFFLINE, 8'h00);
        host.wait_done();
        pulse(4'b0001);
        @(posedge clk);
        check(16'(offline_active), 16'h0001);
    endtask

    // Single place where the run ends; timeouts count as mismatches
    task automatic end_of_test();
        num_errors = num_errors + host.timeouts;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic seen;
        rst_n = 1'b0;
        mon_enabled = 1'b1;
        thresh_exceeded = 1'b0;
        auto_flag = 1'b0;
        offline_secs = 16'h0000;
        {power_save_req, offline_fatal, offline_done, offline_run} = 4'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Reliability query, both outcomes
        for (int t = 0; t < 2; t++) begin
            @(posedge clk);
            thresh_exceeded <= t[0];
            host.send(sdr_pkg::SDR_SUB_STATUS, 8'h00);
            host.wait_done();
            check(16'(host.got_we), 16'h0001);
            check(16'(busy), 16'h0000);
            check({cyl_hi, cyl_lo}, t == 0 ? 16'hc24f : 16'h2cf4);
        end
        // Never started; zero seconds is reported as one
        read_data(8'h00, 16'h0001);
        auto_flag <= 1'b1;
        offline_secs <= 16'hffff;
        start_run();
        pulse(4'b0010);
        read_data(8'h82, 16'hffff);
        start_run();
        pulse(4'b0100);
        read_data(8'h86, 16'hffff);
        // A new command aborts collection; the host acks slowly here
        auto_flag <= 1'b0;
        start_run();
        host.send(sdr_pkg::SDR_SUB_STATUS, 8'h00);
        host.wait_done();
        check(16'(offline_active), 16'h0000);
        host.gap = 2;
        read_data(8'h05, 16'hffff);
        host.gap = 0;
        // Immediate commit, and a save before a power mode change
        host.send(sdr_pkg::SDR_SUB_SAVE_ATTR, 8'h00);
        host.wait_done();
        check(16'(host.got_save), 16'h0001);
        pulse(4'b1000);
        seen = 1'b0;
        repeat (4) begin
            @(posedge clk);
            if (save_pulse === 1'b1) seen = 1'b1;
        end
        check(16'(seen), 16'h0001);
        // Two log sectors written, the first read back
        host.send(sdr_pkg::SDR_SUB_WRITE_LOG, 8'h02);
        host.write_sector(8'h11);
        host.wait_done();
        host.send(sdr_pkg::SDR_SUB_WRITE_LOG, 8'h03);
        host.write_sector(8'h77);
        host.wait_done();
        host.send(sdr_pkg::SDR_SUB_READ_LOG, 8'h02);
        host.read_sector();
        host.wait_done();
        for (int i = 0; i < 512; i++) begin
            check(16'(host.rx[i]), 16'(host.pat(8'h11, i)));
        end
        // Disabled: read data refused, enable accepted; enabled again, unknown code refused
        @(posedge clk);
        mon_enabled <= 1'b0;
        host.send(sdr_pkg::SDR_SUB_READ_DATA, 8'h00);
        host.wait_done();
        check(16'(host.got_abort), 16'h0001);
        host.send(sdr_pkg::SDR_SUB_ENABLE, 8'h00);
        host.wait_done();
        check(16'(host.got_abort), 16'h0000);
        mon_enabled <= 1'b1;
        host.send(8'h00, 8'h00);
        host.wait_done();
        check(16'(host.got_abort), 16'h0001);
        end_of_test();
    end
endmodule
`default_nettype wire
